// file: verilog/cfg_pin_regs.vh
// constants for the configuration pin interface
`ifndef CFG_PIN_REGS_VH
`define CFG_PIN_REGS_VH
`define SYNC_WORD       32'hA5C3_5A3C
`define IMAGE_ID        32'h0000_1234 // value is arbitrary
`define IMAGE_WORDS     16'h0010
`define CRC_INIT        16'hFFFF
`define CRC_POLY        16'h1021
`define IR_LEN          4
`define IR_RESET        4'h1
`define IR_BYPASS       4'hF
`define IR_IDCODE       4'h1
`define IDCODE_VALUE    32'h1000_0001 // value is arbitrary
`define SCLK_DIV        4'h4
`define SYNC_HUNT_MAX   16'h0400
`define RESET_MIN_NS    320
`define CLK_PERIOD_NS   100
`define RESET_MIN_CYC   ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: verilog/cfg_word_buf.v
// two-entry word buffer with valid/ready on both sides
`default_nettype none
module cfg_word_buf #(
  parameter W = 32
) (
  input  wire         i_mclk,
  input  wire         i_resetn,
  input  wire         i_clr,
  input  wire         i_in_valid,
  output wire         o_in_ready,
  input  wire [W-1:0] i_in_data,
  output wire         o_out_valid,
  input  wire         i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push = i_in_valid && (cnt_q != 2'd2);
  wire        pop  = i_out_ready && (cnt_q != 2'd0);

  assign o_in_ready  = (cnt_q != 2'd2);
  assign o_out_valid = (cnt_q != 2'd0);
  assign o_out_data  = mem_q[rp_q];

  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'd0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end
    else if (i_clr)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= i_in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // cfg_word_buf
`default_nettype wire

// file: verilog/config_pin_interface.v
// configuration pin interface: straps, spi loader, status pins and test port
`default_nettype none
`include "cfg_pin_regs.vh"
// Notes on behaviour
// - done is open drain: pull low or release, never drive high.
// - outside pulses reset low long enough; device resets on it.
// - test logic samples mode and data-in on clock rising edge.
// - test data-out changes only after test clock falling edge.
// - undriven test mode and data-in read as one.
// - data-in shifts through instruction or data register chosen by mode.
// - test data-out floats whenever nothing shifts.
// - width straps pick data width; all high means single bit.
// - image select inputs pick image only when multi-image enabled.
// - serial clock is input when passive, output when active.
// - line 0 in passive/out active, line 1 in when active, 32 lines in parallel.
// - load starts only with chip select high; chip select low aborts only the sync hunt.
// - cascade select output enables next device in chain.
// - error low when no sync pattern is found within 1024 hunt bits.
// - error low also on id mismatch, crc fail, update fail.
// - slave select strap sampled at reset release: 0 passive, 1 active.
// - slave select is strap input, then flash select in active mode.
// - after load dual-purpose pins are freed; dedicated pins are not.
module config_pin_interface #(
  parameter DW = 32
) (
  input  wire          i_mclk,
  input  wire          i_resetn,
  input  wire [2:0]    i_data_width_straps,
  input  wire [1:0]    i_image_select_inputs,
  input  wire          i_multi_image_en,
  input  wire          i_config_serial_clock_in,
  output wire          o_config_serial_clock_out,
  output wire          o_config_serial_clock_oe,
  input  wire [DW-1:0] i_config_data_lines,
  output wire [DW-1:0] o_config_data_lines,
  output wire [DW-1:0] o_config_data_lines_oe,
  input  wire          i_chip_select,
  output reg           o_cascade_select_output,
  input  wire          i_slave_select_in,
  output reg           o_slave_select_out,
  output wire          o_slave_select_oe,
  input  wire          i_config_complete_flag_in,
  output wire          o_config_complete_flag_out,
  output wire          o_config_complete_flag_oe,
  output reg           o_config_error_low,
  input  wire          i_remote_update_fail,
  input  wire          i_test_enable_n,
  output reg           o_user_mode,
  output wire          o_user_pins_free,
  output wire          o_word_valid,
  input  wire          i_word_ready,
  output wire [31:0]   o_word_data,
  output wire [1:0]    o_image_index,
  input  wire          i_tck,
  input  wire          i_tms,
  input  wire          i_tdi,
  output reg           o_tdo,
  output reg           o_tdo_oe
);
  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  reg       s1_q;
  reg       s2_q;
  reg [5:0] sp1_q;
  reg [5:0] sp2_q;
  reg [2:0] t1_q;
  reg [2:0] t2_q;
  reg [DW-1:0] d1_q;
  reg [DW-1:0] d2_q;
  reg          cs1_q, cs2_q, ss1_q, ss2_q, dn1_q, dn2_q, te1_q, te2_q;
  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_q <= 1'b1; s2_q <= 1'b1; sp1_q <= 6'h38; sp2_q <= 6'h38;
      t1_q <= 3'b011; t2_q <= 3'b011;
      d1_q <= {DW{1'b0}}; d2_q <= {DW{1'b0}};
      cs1_q <= 1'b0; cs2_q <= 1'b0; ss1_q <= 1'b1; ss2_q <= 1'b1;
      dn1_q <= 1'b0; dn2_q <= 1'b0; te1_q <= 1'b1; te2_q <= 1'b1;
    end
    else
    begin
      s1_q <= i_config_serial_clock_in; s2_q <= s1_q;
      sp1_q <= {i_data_width_straps, i_image_select_inputs, i_multi_image_en}; sp2_q <= sp1_q;
      t1_q <= {i_tck, i_tms, i_tdi}; t2_q <= t1_q;
      d1_q <= i_config_data_lines; d2_q <= d1_q;
      cs1_q <= i_chip_select; cs2_q <= cs1_q;
      ss1_q <= i_slave_select_in; ss2_q <= ss1_q;
      dn1_q <= i_config_complete_flag_in; dn2_q <= dn1_q;
      te1_q <= i_test_enable_n; te2_q <= te1_q;
    end
  end

  // --------------------------------------------------------------
  // strap capture after reset release
  // --------------------------------------------------------------
  reg       strap_done_q, active_q, serial_q;
  reg [1:0] sw_q; // synchronisers hold reset values for two edges after release
  reg [1:0] img_q;
  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      strap_done_q <= 1'b0; active_q <= 1'b0; serial_q <= 1'b1; img_q <= 2'b00;
      sw_q <= 2'd0;
    end
    else if (sw_q != 2'd2)
      sw_q <= sw_q + 2'd1;
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      active_q     <= ss2_q;
      serial_q     <= (sp2_q[5:3] == 3'b111);
      img_q        <= sp2_q[0] ? sp2_q[2:1] : 2'b00;
    end
  end
  assign o_image_index = img_q;

  // --------------------------------------------------------------
  // serial clock: sampled edges when passive, divider when active
  // --------------------------------------------------------------
  reg [3:0] div_q;
  reg       sclk_q;
  wire      div_tick = (div_q == `SCLK_DIV - 4'd1);
  reg       sedge_q;
  wire      p_rise = s2_q && !sedge_q;
  reg       loading;
  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_q <= 4'd0; sclk_q <= 1'b1; sedge_q <= 1'b1; // idle high: no false edge
    end
    else
    begin
      sedge_q <= s2_q;
      div_q   <= div_tick ? 4'd0 : div_q + 4'd1;
      if (div_tick && loading)
        sclk_q <= ~sclk_q;
      else if (!loading)
        sclk_q <= 1'b1;
    end
  end
  wire a_rise = div_tick && loading && !sclk_q;
  wire bit_en = active_q ? a_rise : p_rise;
  assign o_config_serial_clock_out = sclk_q;
  assign o_config_serial_clock_oe  = active_q && loading;

  // --------------------------------------------------------------
  // loader state machine
  // --------------------------------------------------------------
  localparam ST_IDLE = 3'd0, ST_HUNT = 3'd1, ST_ID = 3'd2, ST_DATA = 3'd3,
             ST_CRC = 3'd4, ST_DONE = 3'd5, ST_ERR = 3'd6;
  reg [2:0]  st_q;
  reg [31:0] sh_q;
  reg [5:0]  bc_q;
  reg [15:0] wc_q;
  reg [15:0] crc_q;
  reg        wv_q;
  wire       buf_ready;
  wire [5:0] wbits = serial_q ? 6'd32 : 6'd1;
  wire [31:0] in_word = serial_q ? {sh_q[30:0], d2_q[active_q ? 1 : 0]} : d2_q[31:0];
  wire       word_done = bit_en && (serial_q ? (bc_q == 6'd31) : 1'b1);
  wire       stall = wv_q && !buf_ready;
  reg [15:0] hunt_q;
  always @* loading = (st_q == ST_HUNT) || (st_q == ST_ID) || (st_q == ST_DATA) ||
                      (st_q == ST_CRC);

  function [15:0] crc_step;
    input [15:0] c;
    input [31:0] w;
    integer k;
    reg [15:0] r;
    begin
      r = c;
      for (k = 31; k >= 0; k = k - 1)
        r = (r[15] ^ w[k]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      crc_step = r;
    end
  endfunction

  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q <= ST_IDLE; sh_q <= 32'h0000_0000; bc_q <= 6'd0; wc_q <= 16'h0000;
      crc_q <= `CRC_INIT; wv_q <= 1'b0; hunt_q <= 16'h0000;
      o_config_error_low <= 1'b1; o_cascade_select_output <= 1'b1;
      o_slave_select_out <= 1'b1;
    end
    else
    begin
      if (wv_q && buf_ready)
        wv_q <= 1'b0;
      if (bit_en && !stall && serial_q)
      begin
        sh_q <= in_word;
        bc_q <= (bc_q == wbits - 6'd1) ? 6'd0 : bc_q + 6'd1;
      end
      else if (bit_en && !stall)
        sh_q <= in_word;
      case (st_q)
        ST_IDLE:
          if (strap_done_q && cs2_q && te2_q)
          begin
            st_q <= ST_HUNT;
            o_slave_select_out <= 1'b0;
          end
        ST_HUNT:
        begin
          if (bit_en)
            hunt_q <= hunt_q + 16'h0001;
          if (!cs2_q)
            st_q <= ST_IDLE;
          else if (bit_en && in_word == `SYNC_WORD)
          begin
            st_q <= ST_ID; bc_q <= 6'd0;
          end
          else if (hunt_q == `SYNC_HUNT_MAX)
          begin
            st_q <= ST_ERR; o_config_error_low <= 1'b0;
          end
        end
        ST_ID:
          if (word_done)
          begin
            if (in_word == (`IMAGE_ID + {30'd0, img_q}))
              st_q <= ST_DATA;
            else
            begin
              st_q <= ST_ERR; o_config_error_low <= 1'b0;
            end
          end
        ST_DATA:
          if (word_done && !stall)
          begin
            wv_q  <= 1'b1;
            crc_q <= crc_step(crc_q, in_word);
            wc_q  <= wc_q + 16'h0001;
            if (wc_q == `IMAGE_WORDS - 16'h0001)
              st_q <= ST_CRC;
          end
        ST_CRC:
          if (word_done)
          begin
            if (in_word[15:0] == crc_q)
              st_q <= ST_DONE;
            else
            begin
              st_q <= ST_ERR; o_config_error_low <= 1'b0;
            end
          end
        ST_DONE:
        begin
          o_slave_select_out      <= 1'b1;
          o_cascade_select_output <= 1'b0;
          if (i_remote_update_fail)
          begin
            st_q <= ST_ERR; o_config_error_low <= 1'b0;
          end
        end
        ST_ERR:
          o_slave_select_out <= 1'b1;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  cfg_word_buf #(.W(32)) u_buf (
    .i_mclk      (i_mclk),
    .i_resetn    (i_resetn),
    .i_clr       (st_q == ST_IDLE),
    .i_in_valid  (wv_q),
    .o_in_ready  (buf_ready),
    .i_in_data   (sh_q),
    .o_out_valid (o_word_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_word_data)
  );

  // --------------------------------------------------------------
  // done line, user mode, pin drive
  // --------------------------------------------------------------
  wire ok_done = (st_q == ST_DONE) && o_config_error_low;
  assign o_config_complete_flag_out = 1'b0;
  assign o_config_complete_flag_oe  = !ok_done;
  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_user_mode <= 1'b0;
    else
      // leaves user mode on the same edge that a failed update raises the error
      o_user_mode <= ok_done && dn2_q && !o_word_valid && !i_remote_update_fail;
  end
  assign o_user_pins_free = o_user_mode;
  assign o_slave_select_oe = active_q && strap_done_q;
  assign o_config_data_lines    = {{(DW-1){1'b0}}, sh_q[31]};
  assign o_config_data_lines_oe = (active_q && loading) ? {{(DW-1){1'b0}}, 1'b1} :
                                  {DW{1'b0}};

  // --------------------------------------------------------------
  // test access port
  // --------------------------------------------------------------
  localparam TP_RESET = 4'd0, TP_IDLE = 4'd1, TP_SDR = 4'd2, TP_CDR = 4'd3,
             TP_SHDR = 4'd4, TP_E1DR = 4'd5, TP_PDR = 4'd6, TP_E2DR = 4'd7,
             TP_UDR = 4'd8, TP_SIR = 4'd9, TP_CIR = 4'd10, TP_SHIR = 4'd11,
             TP_E1IR = 4'd12, TP_PIR = 4'd13, TP_E2IR = 4'd14, TP_UIR = 4'd15;
  reg [3:0]  tap_q;
  reg [3:0]  tap_d;
  reg [1:0]  tedge_q;
  reg [`IR_LEN-1:0] ir_q, irs_q;
  reg [31:0] dr_q;
  reg        byp_q;
  wire tck_rise = t2_q[2] && !tedge_q[0];
  wire tck_fall = !t2_q[2] && tedge_q[0];
  wire tms = t2_q[1];
  wire tdi = t2_q[0];
  always @*
  begin
    case (tap_q)
      TP_RESET: tap_d = tms ? TP_RESET : TP_IDLE;
      TP_IDLE:  tap_d = tms ? TP_SDR : TP_IDLE;
      TP_SDR:   tap_d = tms ? TP_SIR : TP_CDR;
      TP_CDR:   tap_d = tms ? TP_E1DR : TP_SHDR;
      TP_SHDR:  tap_d = tms ? TP_E1DR : TP_SHDR;
      TP_E1DR:  tap_d = tms ? TP_UDR : TP_PDR;
      TP_PDR:   tap_d = tms ? TP_E2DR : TP_PDR;
      TP_E2DR:  tap_d = tms ? TP_UDR : TP_SHDR;
      TP_UDR:   tap_d = tms ? TP_SDR : TP_IDLE;
      TP_SIR:   tap_d = tms ? TP_RESET : TP_CIR;
      TP_CIR:   tap_d = tms ? TP_E1IR : TP_SHIR;
      TP_SHIR:  tap_d = tms ? TP_E1IR : TP_SHIR;
      TP_E1IR:  tap_d = tms ? TP_UIR : TP_PIR;
      TP_PIR:   tap_d = tms ? TP_E2IR : TP_PIR;
      TP_E2IR:  tap_d = tms ? TP_UIR : TP_SHIR;
      TP_UIR:   tap_d = tms ? TP_SDR : TP_IDLE;
      default:  tap_d = TP_RESET;
    endcase
  end
  wire sel_byp = (ir_q == `IR_BYPASS) || (ir_q != `IR_IDCODE);
  always @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tedge_q <= 2'b00; tap_q <= TP_RESET; ir_q <= `IR_RESET; irs_q <= `IR_RESET;
      dr_q <= 32'h0000_0000; byp_q <= 1'b0; o_tdo <= 1'b0; o_tdo_oe <= 1'b0;
    end
    else
    begin
      tedge_q <= {tedge_q[0], t2_q[2]};
      if (tck_rise)
      begin
        tap_q <= tap_d;
        case (tap_q)
          TP_RESET: ir_q <= `IR_RESET;
          TP_CIR:   irs_q <= `IR_RESET;
          TP_SHIR:  irs_q <= {tdi, irs_q[`IR_LEN-1:1]};
          TP_UIR:   ir_q <= irs_q;
          TP_CDR:
          begin
            dr_q  <= `IDCODE_VALUE;
            byp_q <= 1'b0;
          end
          TP_SHDR:
          begin
            dr_q  <= {tdi, dr_q[31:1]};
            byp_q <= tdi;
          end
          default: byp_q <= byp_q;
        endcase
      end
      if (tck_fall)
      begin
        o_tdo_oe <= (tap_q == TP_SHIR) || (tap_q == TP_SHDR);
        o_tdo    <= (tap_q == TP_SHIR) ? irs_q[0] : (sel_byp ? byp_q : dr_q[0]);
      end
    end
  end
endmodule // config_pin_interface
`default_nettype wire

// file: tb/config_pin_monitor.sv
// assertion checker for the configuration pin interface
`default_nettype none
module config_pin_monitor #(
  parameter int DW = 32
) (
  input wire logic          i_mclk,
  input wire logic          i_resetn,
  input wire logic          i_tck,
  input wire logic          i_config_complete_flag_in,
  input wire logic          o_config_complete_flag_out,
  input wire logic          o_config_complete_flag_oe,
  input wire logic          o_config_error_low,
  input wire logic          o_user_mode,
  input wire logic          o_user_pins_free,
  input wire logic          o_cascade_select_output,
  input wire logic          o_slave_select_oe,
  input wire logic          o_config_serial_clock_oe,
  input wire logic [DW-1:0] o_config_data_lines_oe,
  input wire logic          o_tdo,
  input wire logic          o_tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ------------------------------------------------------------
  // status pins
  // ------------------------------------------------------------
  a_done_open_drain: assert property (o_config_complete_flag_out == 1'b0)
    else $error("done line driven high");
  a_done_needs_ok: assert property ($fell(o_config_complete_flag_oe) |-> o_config_error_low)
    else $error("done released with error flagged");
  a_error_sticky: assert property ($fell(o_config_error_low) |=> !o_config_error_low [*8])
    else $error("error flag dropped early");
  a_user_waits_done: assert property ($rose(o_user_mode) |-> $past(i_config_complete_flag_in))
    else $error("user mode while done held low");
  a_user_after_done: assert property (o_user_mode |-> !o_config_complete_flag_oe)
    else $error("user mode before done");
  a_pins_free_user: assert property (o_user_pins_free == o_user_mode)
    else $error("pins freed outside user mode");
  a_cascade_when_ok: assert property ($fell(o_cascade_select_output) |-> o_config_error_low)
    else $error("cascade enabled after error");
  // ------------------------------------------------------------
  // pin directions and test port
  // ------------------------------------------------------------
  a_clock_in_passive: assert property (!o_slave_select_oe |-> !o_config_serial_clock_oe)
    else $error("serial clock driven in passive mode");
  a_line0_passive: assert property (!o_slave_select_oe |-> !o_config_data_lines_oe[0])
    else $error("data line 0 driven in passive mode");
  a_tdo_on_fall: assert property ($changed(o_tdo) |-> !i_tck)
    else $error("test data out moved while clock high");
  c_user: cover property ($rose(o_user_mode));
  c_error: cover property ($fell(o_config_error_low));
  c_shift: cover property ($rose(o_tdo_oe));
endmodule // config_pin_monitor
bind config_pin_interface config_pin_monitor #(.DW(DW)) u_mon (.*);
`default_nettype wire

// file: tb/cfg_host.sv
// passive serial host model driving the clock and data lines
`default_nettype none
module cfg_host (
  output var logic        o_sclk,
  output var logic [31:0] o_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_sclk  = 1'b1;
    o_lines = 32'h0000_0000;
  end
  // clock is driven high at rest and toggles only inside a frame
  task automatic send(input logic [31:0] w, input logic par);
    for (int i = 31; i >= 0; i--)
    begin
      o_sclk  = 1'b0;
      o_lines = par ? w : {~o_lines[31:1], w[i]};
      #400 o_sclk = 1'b1;
      #400;
      if (par)
        break;
    end
    // released lines must not keep showing the last value
    o_lines = ~o_lines;
  endtask
endmodule // cfg_host
`default_nettype wire

// file: tb/config_pin_interface_tb.sv
// self-checking bench for the configuration pin interface
`default_nettype none
`include "cfg_pin_regs.vh"
module config_pin_interface_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 1'b0, i_resetn = 1'b0, i_multi_image_en = 1'b0, i_chip_select = 1'b1;
  logic        i_remote_update_fail = 1'b0, i_word_ready = 1'b1, i_tck = 1'b0;
  logic        i_test_enable_n = 1'b1;
  logic        i_tms = 1'b1, i_tdi = 1'b1;
  logic        ss_strap = 1'b0, hold_done = 1'b0;
  logic [2:0]  i_data_width_straps = 3'b111;
  logic [1:0]  i_image_select_inputs = 2'b10;
  wire logic   i_config_serial_clock_in, i_slave_select_in, i_config_complete_flag_in, host_clk;
  wire logic   o_config_serial_clock_out, o_config_serial_clock_oe, o_cascade_select_output;
  wire logic   o_slave_select_out, o_slave_select_oe, o_config_complete_flag_out;
  wire logic   o_config_complete_flag_oe, o_config_error_low, o_user_mode, o_user_pins_free;
  wire logic   o_word_valid, o_tdo, o_tdo_oe;
  wire logic [1:0]  o_image_index;
  wire logic [31:0] i_config_data_lines, host_lines, o_config_data_lines;
  wire logic [31:0] o_config_data_lines_oe, o_word_data;
  logic [31:0] got[$];
  int          err_count = 0, check_count = 0;
  // ------------------------------------------------------------
  // wires, models and clock
  // ------------------------------------------------------------
  assign i_config_serial_clock_in = o_config_serial_clock_oe ? o_config_serial_clock_out
                                                             : host_clk;
  assign i_config_data_lines = (o_config_data_lines_oe & o_config_data_lines)
                             | (~o_config_data_lines_oe & host_lines);
  assign i_slave_select_in = o_slave_select_oe ? o_slave_select_out : ss_strap;
  // open drain with pull-up, optionally held low from outside
  assign i_config_complete_flag_in = !o_config_complete_flag_oe && !hold_done;
  config_pin_interface #(.DW(32)) dut (.*);
  cfg_host host (.o_sclk(host_clk), .o_lines(host_lines));
  initial
    forever #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
    if (o_word_valid === 1'b1 && i_word_ready)
      got.push_back(o_word_data);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] dw(input int k);
    return 32'h0f1e_2d3c ^ (k * 32'h0101_0101);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic rst(input logic [2:0] wd, input logic mi);
    i_resetn = 1'b0;
    i_data_width_straps = wd;
    i_multi_image_en = mi;
    got.delete();
    cyc(`RESET_MIN_CYC + 1);
    chk("error in reset", o_config_error_low, 1'b1);
    chk("done oe in reset", o_config_complete_flag_oe, 1'b1);
    chk("user in reset", o_user_mode, 1'b0);
    i_resetn = 1'b1;
    cyc(3);
  endtask
  task automatic load(input logic par, input logic bad, input logic [1:0] idx);
    logic [15:0] c;
    logic [31:0] d;
    c = `CRC_INIT;
    host.send(`SYNC_WORD, par);
    host.send(`IMAGE_ID + idx, par);
    for (int k = 0; k < `IMAGE_WORDS; k++)
    begin
      d = dw(k);
      for (int i = 31; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRC_POLY : 16'h0000);
      host.send(d, par);
    end
    chk("done before crc", o_config_complete_flag_oe, 1'b1);
    host.send({16'h0000, c ^ {15'h0000, bad}}, par);
    cyc(20);
  endtask
  task automatic words_ok();
    chk("word count", got.size(), 32'h0000_0010);
    foreach (got[k]) chk("word", got[k], dw(k));
  endtask
  task automatic jclk(input logic tms, output logic b);
    i_tms = tms;
    #400 b = o_tdo;
    i_tck = 1'b1;
    #400 i_tck = 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_serial_ok();
    hold_done = 1'b1;
    rst(3'b111, 1'b1);
    fork
      load(1'b0, 1'b0, 2'b10);
      begin
        cyc(1500);
        i_word_ready = 1'b0;
        cyc(300);
        i_word_ready = 1'b1;
      end
    join
    words_ok();
    chk("image index", o_image_index, 2'b10);
    chk("error", o_config_error_low, 1'b1);
    chk("done oe", o_config_complete_flag_oe, 1'b0);
    chk("user while held", o_user_mode, 1'b0);
    hold_done = 1'b0;
    cyc(4);
    chk("user", o_user_mode, 1'b1);
    chk("pins free", o_user_pins_free, 1'b1);
    chk("cascade", o_cascade_select_output, 1'b0);
    i_remote_update_fail = 1'b1;
    cyc(4);
    chk("update fail", o_config_error_low, 1'b0);
    i_remote_update_fail = 1'b0;
  endtask
  task automatic t_par_ok();
    rst(3'b000, 1'b0);
    load(1'b1, 1'b0, 2'b00);
    words_ok();
    chk("image index", o_image_index, 2'b00);
    chk("done oe", o_config_complete_flag_oe, 1'b0);
  endtask
  task automatic t_par_bad_crc();
    rst(3'b000, 1'b0);
    load(1'b1, 1'b1, 2'b00);
    chk("crc error", o_config_error_low, 1'b0);
    chk("done oe", o_config_complete_flag_oe, 1'b1);
    chk("user", o_user_mode, 1'b0);
  endtask
  task automatic t_no_select();
    i_chip_select = 1'b0;
    rst(3'b000, 1'b0);
    load(1'b1, 1'b0, 2'b00);
    chk("unselected words", got.size(), 32'h0000_0000);
    chk("unselected done", o_config_complete_flag_oe, 1'b1);
    i_chip_select = 1'b1;
  endtask
  task automatic t_no_sync();
    rst(3'b111, 1'b0);
    repeat (33) host.send(32'h0000_0000, 1'b0);
    cyc(10);
    chk("sync missing", o_config_error_low, 1'b0);
    chk("done oe", o_config_complete_flag_oe, 1'b1);
  endtask
  task automatic t_active();
    logic c;
    ss_strap = 1'b1;
    rst(3'b111, 1'b0);
    cyc(20);
    chk("flash select oe", o_slave_select_oe, 1'b1);
    chk("flash select", o_slave_select_out, 1'b0);
    chk("clock oe", o_config_serial_clock_oe, 1'b1);
    chk("line0 oe", o_config_data_lines_oe[0], 1'b1);
    c = o_config_serial_clock_out;
    cyc(4);
    chk("clock toggles", o_config_serial_clock_out, !c);
    ss_strap = 1'b0;
  endtask
  task automatic t_tap();
    logic        b;
    logic [31:0] id;
    logic [8:0]  seq;
    logic [12:0] mv;
    seq = 9'h1f4;
    mv = 13'h1834;
    rst(3'b111, 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      if (i == 6)
        chk("tdo idle", o_tdo_oe, 1'b0);
      jclk(seq[8-i], b);
    end
    for (int i = 0; i < 32; i++)
    begin
      jclk(i == 31, b);
      id[i] = b;
      if (i == 0)
        chk("tdo shifting", o_tdo_oe, 1'b1);
    end
    chk("id shift", id, `IDCODE_VALUE);
    jclk(1'b1, b);
    jclk(1'b0, b);
    cyc(4);
    chk("tdo released", o_tdo_oe, 1'b0);
    // load the bypass code, then a bypass bit shows one clock late
    i_tdi = 1'b1;
    for (int i = 0; i < 13; i++)
      jclk(mv[12-i], b);
    jclk(1'b0, b);
    chk("bypass capture", b, 1'b0);
    i_tdi = 1'b0;
    jclk(1'b0, b);
    chk("bypass shift", b, 1'b1);
    i_tdi = 1'b1;
  endtask
  task automatic give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    t_tap();
    t_par_ok();
    t_par_bad_crc();
    t_no_select();
    t_active();
    t_serial_ok();
    t_no_sync();
    give_verdict();
  end
  // the full sequence needs about 1.5 ms
  initial
  begin
    #3_000_000;
    err_count++;
    give_verdict();
  end
endmodule // config_pin_interface_tb
`default_nettype wire
